// *** include/gpio_port_pkg.sv ***
// Constants and encodings for the five-pin PWM port
package gpio_port_pkg;
  // ----------------------------------------
  // Geometry and clocking
  // ----------------------------------------
  localparam int PIN_COUNT = 5;
  localparam int CLK_HZ = 50_000_000;
  localparam int PWM_FREQ_HZ = 100;
  localparam int PWM_STEPS = 100;
  localparam int SAMPLE_FREQ_HZ = 32;
  localparam int PWM_STEP_CYCLES = CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS);
  localparam int SAMPLE_CYCLES = CLK_HZ / SAMPLE_FREQ_HZ;
  // ----------------------------------------
  // Command packet
  // ----------------------------------------
  localparam logic [7:0] CMD_SET_PIN = 8'h22;
  localparam logic [7:0] REPLY_SET_PIN = 8'h62;
  localparam logic [7:0] REPLY_LEN = 8'h00;
  localparam logic [7:0] LEN_VALUE_ONLY = 8'h02;
  localparam logic [7:0] LEN_VALUE_CFG = 8'h03;
  localparam logic [7:0] LEVEL_LOW = 8'h00;
  localparam logic [7:0] LEVEL_HIGH = 8'h64;
  localparam logic [7:0] FIRST_RESERVED_INDEX = 8'h05;
  // ----------------------------------------
  // Configuration byte fields
  // ----------------------------------------
  localparam int FUNC_BIT = 3;
  localparam int MODE_MSB = 2;
  localparam logic [2:0] MODE_UP_FAST_PULLDN = 3'h0;
  localparam logic [2:0] MODE_FAST_BOTH = 3'h1;
  localparam logic [2:0] MODE_HIZ = 3'h2;
  localparam logic [2:0] MODE_PULLUP_FAST_DN = 3'h3;
  localparam logic [2:0] MODE_SLOW_UP_HIZ = 3'h4;
  localparam logic [2:0] MODE_SLOW_BOTH = 3'h5;
  localparam logic [2:0] MODE_RESERVED = 3'h6;
  localparam logic [2:0] MODE_HIZ_SLOW_DN = 3'h7;
  // ----------------------------------------
  // Factory state, pin 4 leftmost
  // ----------------------------------------
  localparam logic [4:0][3:0] FACTORY_CFG = {4'h2, 4'h2, 4'h2, 4'h3, 4'h2};
  localparam logic [4:0][7:0] FACTORY_LEVEL = {8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
endpackage

// *** design/gpio_pwm_port_config.sv ***
// Five-pin PWM and input-sampling port configured by command packets
// What this block does
// - Index 0 to 4 selects a pin; index 5 and above touches nothing.
// - Level 0 holds pin low, 100 holds it high, above 100 is invalid.
// - Levels 1 to 99 give a 100 Hz PWM with that high percentage.
// - Length 2 sets level only; length 3 also sets function and drive mode.
// - Modes 000 to 011: push-pull, pull-down, Hi-Z and pull-up variants, fast.
// - Modes 100, 101, 111 are slow variants; 110 is reserved.
// - Function 1 gives the pin to the user, 0 to its default role.
// - Every pin is sampled at 32 Hz regardless of queries.
// - Rising and falling edges between samples are latched per pin.
// - Pins 1 to 4 carry power sense, power, reset and one-wire roles.
// - Store-boot captures pin settings; restore-boot reloads them.
// - An accepted set command answers with type 0x62, no data.
// - Pull-up modes let a switch to ground read 1 open, 0 closed.
// - Status read returns sampled level and falling and rising flags.
module gpio_pwm_port_config #(
  parameter int PWM_STEP = gpio_port_pkg::PWM_STEP_CYCLES,
  parameter int SAMPLE_PERIOD = gpio_port_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Set command
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_TYPE,
  input wire logic [7:0] CMD_LEN,
  input wire logic [7:0] CMD_INDEX,
  input wire logic [7:0] CMD_LEVEL,
  input wire logic [7:0] CMD_CFG,
  // Reply
  output logic RPL_VALID,
  output logic [7:0] RPL_TYPE,
  output logic [7:0] RPL_LEN,
  // Status query
  input wire logic QRY_VALID,
  input wire logic [7:0] QRY_INDEX,
  output logic QRY_RESP_VALID,
  output logic [7:0] QRY_RESP_INDEX,
  output logic [2:0] QRY_RESP_FLAGS,
  output logic [7:0] QRY_RESP_LEVEL,
  output logic [3:0] QRY_RESP_CFG,
  // Boot state
  input wire logic STORE_BOOT,
  input wire logic RESTORE_BOOT,
  // Default roles
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0] ROLE_OUT,
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0] ROLE_OE,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] ROLE_IN,
  // Pads
  input wire logic [gpio_port_pkg::PIN_COUNT-1:0] PIN_IN,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] PIN_OUT,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] PIN_OE,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] PIN_PULL_UP,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] PIN_PULL_DN,
  output logic [gpio_port_pkg::PIN_COUNT-1:0] PIN_SLOW
);
  import gpio_port_pkg::*;

  typedef struct packed {
    logic [4:0][7:0] level;
    logic [4:0][3:0] cfg;
    logic [4:0][7:0] boot_level;
    logic [4:0][3:0] boot_cfg;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [4:0] sample;
    logic [4:0] rise;
    logic [4:0] fall;
    logic [31:0] step_cnt;
    logic [6:0] phase;
    logic [31:0] samp_cnt;
    logic rpl_valid;
    logic qry_valid;
    logic [7:0] qry_index;
    logic [2:0] qry_flags;
    logic [7:0] qry_level;
    logic [3:0] qry_cfg;
    logic [4:0] pin_out;
    logic [4:0] pin_oe;
    logic [4:0] pin_pu;
    logic [4:0] pin_pd;
    logic [4:0] pin_slow;
  } state_t;

  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
    logic pd;
    logic slow;
  } drive_t;

  state_t st_reg;
  state_t st_next;

  // ----------------------------------------
  // Drive mode decode
  // ----------------------------------------
  function automatic drive_t decode_drive(input logic [2:0] mode, input logic lvl);
    drive_t d;
    d = '0;
    case (mode)
      MODE_UP_FAST_PULLDN: begin
        d.oe = lvl;
        d.out = lvl;
        d.pd = ~lvl;
      end
      MODE_FAST_BOTH: begin
        d.oe = 1'b1;
        d.out = lvl;
      end
      MODE_HIZ: d = '0;
      MODE_PULLUP_FAST_DN: begin
        d.oe = ~lvl;
        d.pu = lvl;
      end
      MODE_SLOW_UP_HIZ: begin
        d.oe = lvl;
        d.out = lvl;
        d.slow = lvl;
      end
      MODE_SLOW_BOTH: begin
        d.oe = 1'b1;
        d.out = lvl;
        d.slow = 1'b1;
      end
      MODE_HIZ_SLOW_DN: begin
        d.oe = ~lvl;
        d.slow = ~lvl;
      end
      default: d = '0;
    endcase
    return d;
  endfunction

  logic cmd_ok;
  logic step_tick;
  logic samp_tick;
  logic [4:0] pwm_on;
  logic [7:0] lvl_new;

  assign cmd_ok = CMD_VALID && (CMD_TYPE == CMD_SET_PIN) && (CMD_INDEX < FIRST_RESERVED_INDEX)
    && (CMD_LEVEL <= LEVEL_HIGH) && (CMD_LEN == LEN_VALUE_ONLY || CMD_LEN == LEN_VALUE_CFG);
  assign step_tick = st_reg.step_cnt == 32'(PWM_STEP - 1);
  assign samp_tick = st_reg.samp_cnt == 32'(SAMPLE_PERIOD - 1);
  assign lvl_new = CMD_LEVEL;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    drive_t d;
    logic lvl;
    int unsigned qi;
    d = '0;
    lvl = 1'b0;
    qi = 0;
    st_next = st_reg;
    st_next.rpl_valid = cmd_ok;
    st_next.qry_valid = 1'b0;
    // PWM time base: 100 steps per period
    st_next.step_cnt = step_tick ? 32'h0 : st_reg.step_cnt + 32'h1;
    if (step_tick) begin
      st_next.phase = (st_reg.phase == 7'(PWM_STEPS - 1)) ? 7'h0 : st_reg.phase + 7'h1;
    end
    // Input sampling
    st_next.sync1 = PIN_IN;
    st_next.sync2 = st_reg.sync1;
    st_next.samp_cnt = samp_tick ? 32'h0 : st_reg.samp_cnt + 32'h1;
    if (samp_tick) begin
      st_next.sample = st_reg.sync2;
    end
    // Query answers old flags then clears; a new edge wins
    if (QRY_VALID && QRY_INDEX < FIRST_RESERVED_INDEX) begin
      qi = int'(QRY_INDEX[2:0]);
      st_next.qry_valid = 1'b1;
      st_next.qry_index = QRY_INDEX;
      st_next.qry_flags = {st_reg.rise[qi], st_reg.fall[qi], st_reg.sample[qi]};
      st_next.qry_level = st_reg.level[qi];
      st_next.qry_cfg = st_reg.cfg[qi];
      st_next.rise[qi] = 1'b0;
      st_next.fall[qi] = 1'b0;
    end
    if (samp_tick) begin
      st_next.rise = st_next.rise | (st_reg.sync2 & ~st_reg.sample);
      st_next.fall = st_next.fall | (~st_reg.sync2 & st_reg.sample);
    end
    // Configuration
    if (cmd_ok) begin
      st_next.level[CMD_INDEX[2:0]] = lvl_new;
      if (CMD_LEN == LEN_VALUE_CFG) begin
        st_next.cfg[CMD_INDEX[2:0]] = CMD_CFG[FUNC_BIT:0];
      end
    end
    if (STORE_BOOT) begin
      st_next.boot_level = st_reg.level;
      st_next.boot_cfg = st_reg.cfg;
    end
    if (RESTORE_BOOT) begin
      st_next.level = st_reg.boot_level;
      st_next.cfg = st_reg.boot_cfg;
    end
    // Pad drive
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (st_reg.cfg[i][FUNC_BIT]) begin
        d = decode_drive(st_reg.cfg[i][MODE_MSB:0], pwm_on[i]);
      end else begin
        // Default role drives the pin itself; mode sets the pulls
        lvl = ROLE_OUT[i];
        d = decode_drive(st_reg.cfg[i][MODE_MSB:0], lvl);
        d.oe = ROLE_OE[i];
        d.out = lvl;
        d.slow = 1'b0;
      end
      st_next.pin_oe[i] = d.oe;
      st_next.pin_out[i] = d.out & d.oe;
      st_next.pin_pu[i] = d.pu;
      st_next.pin_pd[i] = d.pd;
      st_next.pin_slow[i] = d.slow;
    end
    if (RESET) begin
      st_next = '0;
      st_next.level = FACTORY_LEVEL;
      st_next.cfg = FACTORY_CFG;
      st_next.boot_level = FACTORY_LEVEL;
      st_next.boot_cfg = FACTORY_CFG;
    end
  end

  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      pwm_on[i] = {1'b0, st_reg.phase} < st_reg.level[i];
    end
  end

  always_ff @(posedge CLK) begin
    st_reg <= st_next;
  end

  assign RPL_VALID = st_reg.rpl_valid;
  assign RPL_TYPE = REPLY_SET_PIN;
  assign RPL_LEN = REPLY_LEN;
  assign QRY_RESP_VALID = st_reg.qry_valid;
  assign QRY_RESP_INDEX = st_reg.qry_index;
  assign QRY_RESP_FLAGS = st_reg.qry_flags;
  assign QRY_RESP_LEVEL = st_reg.qry_level;
  assign QRY_RESP_CFG = st_reg.qry_cfg;
  assign ROLE_IN = st_reg.sample;
  assign PIN_OUT = st_reg.pin_out;
  assign PIN_OE = st_reg.pin_oe;
  assign PIN_PULL_UP = st_reg.pin_pu;
  assign PIN_PULL_DN = st_reg.pin_pd;
  assign PIN_SLOW = st_reg.pin_slow;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  property p_reserved_index;
    CMD_VALID && CMD_INDEX >= FIRST_RESERVED_INDEX && !RESTORE_BOOT
      |=> !RPL_VALID && $stable(st_reg.level) && $stable(st_reg.cfg);
  endproperty
  a_reserved_index: assert property (p_reserved_index) else $error("Reserved index changed state");

  property p_level_high;
    st_reg.cfg[0] == 4'h9 && st_reg.level[0] == LEVEL_HIGH |=> PIN_OE[0] && PIN_OUT[0];
  endproperty
  a_level_high: assert property (p_level_high) else $error("Level 100 not driven high");

  property p_pwm_follow;
    st_reg.cfg[0] == 4'h9 ##1 st_reg.cfg[0] == 4'h9 |-> PIN_OUT[0] == ($past(st_reg.phase) < $past(st_reg.level[0]));
  endproperty
  a_pwm_follow: assert property (p_pwm_follow) else $error("PWM output wrong");

  property p_len_two;
    cmd_ok && CMD_LEN == LEN_VALUE_ONLY && !RESTORE_BOOT |=> $stable(st_reg.cfg) && st_reg.level[$past(CMD_INDEX[2:0])] == $past(CMD_LEVEL);
  endproperty
  a_len_two: assert property (p_len_two) else $error("Length 2 altered configuration");

  property p_hiz;
    st_reg.cfg[1] == 4'ha |=> !PIN_OE[1] && !PIN_PULL_UP[1] && !PIN_PULL_DN[1];
  endproperty
  a_hiz: assert property (p_hiz) else $error("Hi-Z mode drove pin");

  property p_slow_dn;
    st_reg.cfg[1] == 4'hf && st_reg.level[1] == LEVEL_LOW |=> PIN_OE[1] && !PIN_OUT[1] && PIN_SLOW[1];
  endproperty
  a_slow_dn: assert property (p_slow_dn) else $error("Mode 111 low not slow drive down");

  property p_role;
    !st_reg.cfg[2][FUNC_BIT] |=> PIN_OE[2] == $past(ROLE_OE[2]);
  endproperty
  a_role: assert property (p_role) else $error("Default role lost the pin");

  property p_pullup;
    st_reg.cfg[1] == 4'hb && st_reg.level[1] == LEVEL_HIGH |=> PIN_PULL_UP[1] && !PIN_OE[1];
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up mode wrong");

  property p_sample_hold;
    !samp_tick |=> $stable(st_reg.sample);
  endproperty
  a_sample_hold: assert property (p_sample_hold) else $error("Sample moved off tick");

  property p_rise;
    samp_tick && st_reg.sync2[3] && !st_reg.sample[3] |=> st_reg.rise[3];
  endproperty
  a_rise: assert property (p_rise) else $error("Rising edge not latched");

  property p_reply;
    cmd_ok |=> RPL_VALID && RPL_TYPE == 8'h62 && RPL_LEN == 8'h00 ##1 RPL_VALID == $past(cmd_ok);
  endproperty
  a_reply: assert property (p_reply) else $error("Reply missing");

  property p_clear;
    QRY_VALID && QRY_INDEX == 8'h03 && !samp_tick |=> QRY_RESP_VALID && !st_reg.rise[3] && !st_reg.fall[3];
  endproperty
  a_clear: assert property (p_clear) else $error("Query left flags set");

  property p_restore;
    RESTORE_BOOT |=> st_reg.cfg == $past(st_reg.boot_cfg) && st_reg.level == $past(st_reg.boot_level);
  endproperty
  a_restore: assert property (p_restore) else $error("Boot restore failed");

  property p_bad_level;
    CMD_VALID && CMD_LEVEL > LEVEL_HIGH && !RESTORE_BOOT |=> $stable(st_reg.level) && !RPL_VALID;
  endproperty
  a_bad_level: assert property (p_bad_level) else $error("Invalid level accepted");

  c_cfg_write: cover property (cmd_ok && CMD_LEN == LEN_VALUE_CFG);
  c_pwm_mid: cover property (st_reg.level[0] == 8'h32 && st_reg.cfg[0][FUNC_BIT]);
  c_fall_query: cover property (QRY_VALID && st_reg.fall[3]);
  c_restore: cover property (STORE_BOOT ##[1:20] RESTORE_BOOT);
endmodule

// *** sim/host_model.sv ***
// Host side model issuing set, query and boot strobes
module host_model
  import gpio_port_pkg::*;
(
  // Clock and answers
  input wire logic CLK,
  input wire logic RPL_VALID,
  input wire logic QRY_RESP_VALID,
  // Requests
  output logic CMD_VALID,
  output logic [7:0] CMD_TYPE,
  output logic [7:0] CMD_LEN,
  output logic [7:0] CMD_INDEX,
  output logic [7:0] CMD_LEVEL,
  output logic [7:0] CMD_CFG,
  output logic QRY_VALID,
  output logic [7:0] QRY_INDEX,
  output logic STORE_BOOT,
  output logic RESTORE_BOOT
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {CMD_VALID, CMD_TYPE, CMD_LEN, CMD_INDEX, CMD_LEVEL, CMD_CFG} = '0;
    {QRY_VALID, QRY_INDEX, STORE_BOOT, RESTORE_BOOT} = '0;
  end
  // Answer seen in the two cycles after the taking edge
  task automatic send(input logic [7:0] t, l, i, v, c, output logic [1:0] r);
    @(negedge CLK);
    CMD_VALID = 1'b1;
    {CMD_TYPE, CMD_LEN, CMD_INDEX, CMD_LEVEL} = {t, l, i, v};
    CMD_CFG = {4'h0, c[3:0]};
    @(negedge CLK);
    CMD_VALID = 1'b0;
    // Released fields no longer show the last value
    {CMD_TYPE, CMD_LEN, CMD_INDEX, CMD_LEVEL, CMD_CFG} = ~{t, l, i, v, 4'h0, c[3:0]};
    r[1] = RPL_VALID;
    @(negedge CLK);
    r[0] = RPL_VALID;
  endtask
  task automatic query(input logic [7:0] i, output logic [1:0] r);
    @(negedge CLK);
    QRY_VALID = 1'b1;
    QRY_INDEX = i;
    @(negedge CLK);
    QRY_VALID = 1'b0;
    QRY_INDEX = ~i;
    r[1] = QRY_RESP_VALID;
    @(negedge CLK);
    r[0] = QRY_RESP_VALID;
  endtask
  task automatic strobe(input bit store);
    @(negedge CLK);
    {STORE_BOOT, RESTORE_BOOT} = store ? 2'b10 : 2'b01;
    @(negedge CLK);
    {STORE_BOOT, RESTORE_BOOT} = 2'b00;
  endtask
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the five-pin PWM port
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import gpio_port_pkg::*;
  localparam int STEP = 4;
  // {oe, out, pull up, pull down, slow while driving}, low then high per mode
  localparam logic [4:0] mode_exp [16] = '{5'h02, 5'h18, 5'h10, 5'h18, 5'h00, 5'h00, 5'h10, 5'h04,
    5'h00, 5'h19, 5'h11, 5'h19, 5'h00, 5'h00, 5'h11, 5'h00};
  localparam logic [39:0] bad_cmds [6] = '{40'h22_03_05_32_09, 40'h22_03_ff_32_09, 40'h22_03_00_65_09,
    40'h22_04_00_32_09, 40'h22_01_00_32_09, 40'h21_03_00_32_09};
  localparam logic [7:0] pwm_lv [3] = '{8'h01, 8'h32, 8'h63};
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic cmd_valid, qry_valid, store_boot, restore_boot, rpl_valid, qry_resp_valid;
  logic [7:0] cmd_type, cmd_len, cmd_index, cmd_level, cmd_cfg, qry_index;
  logic [7:0] RPL_TYPE, RPL_LEN, QRY_RESP_INDEX, QRY_RESP_LEVEL;
  logic [2:0] QRY_RESP_FLAGS;
  logic [3:0] QRY_RESP_CFG;
  logic [4:0] role_out = '0, role_oe = '0, pin_in = '0;
  logic [4:0] ROLE_IN, PIN_OUT, PIN_OE, PIN_PULL_UP, PIN_PULL_DN, PIN_SLOW;
  int bad_count = 0;
  int num_checks = 0;
  always #10 CLK = ~CLK;
  host_model u_host_model (.CLK(CLK), .RPL_VALID(rpl_valid), .QRY_RESP_VALID(qry_resp_valid),
    .CMD_VALID(cmd_valid), .CMD_TYPE(cmd_type), .CMD_LEN(cmd_len), .CMD_INDEX(cmd_index),
    .CMD_LEVEL(cmd_level), .CMD_CFG(cmd_cfg), .QRY_VALID(qry_valid), .QRY_INDEX(qry_index),
    .STORE_BOOT(store_boot), .RESTORE_BOOT(restore_boot));
  gpio_pwm_port_config #(.PWM_STEP(STEP), .SAMPLE_PERIOD(8)) u_gpio_pwm_port_config (.CLK(CLK), .RESET(RESET),
    .CMD_VALID(cmd_valid), .CMD_TYPE(cmd_type), .CMD_LEN(cmd_len), .CMD_INDEX(cmd_index),
    .CMD_LEVEL(cmd_level), .CMD_CFG(cmd_cfg), .RPL_VALID(rpl_valid), .RPL_TYPE(RPL_TYPE),
    .RPL_LEN(RPL_LEN), .QRY_VALID(qry_valid), .QRY_INDEX(qry_index), .QRY_RESP_VALID(qry_resp_valid),
    .QRY_RESP_INDEX(QRY_RESP_INDEX), .QRY_RESP_FLAGS(QRY_RESP_FLAGS), .QRY_RESP_LEVEL(QRY_RESP_LEVEL),
    .QRY_RESP_CFG(QRY_RESP_CFG), .STORE_BOOT(store_boot), .RESTORE_BOOT(restore_boot),
    .ROLE_OUT(role_out), .ROLE_OE(role_oe), .ROLE_IN(ROLE_IN), .PIN_IN(pin_in), .PIN_OUT(PIN_OUT),
    .PIN_OE(PIN_OE), .PIN_PULL_UP(PIN_PULL_UP), .PIN_PULL_DN(PIN_PULL_DN), .PIN_SLOW(PIN_SLOW));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge CLK);
  endtask
  task automatic cmd(input logic [7:0] t, l, i, v, c, input logic [1:0] e);
    logic [1:0] r;
    u_host_model.send(t, l, i, v, c, r);
    check(r, e);
  endtask
  task automatic qchk(input logic [7:0] i, lv, input logic [3:0] cf, input logic [2:0] fl);
    logic [1:0] r;
    u_host_model.query(i, r);
    check(r, 2'b10);
    check({QRY_RESP_INDEX, QRY_RESP_LEVEL, QRY_RESP_CFG, QRY_RESP_FLAGS}, {i, lv, cf, fl});
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [1:0] r;
    for (int i = 0; i < 5; i++) qchk(8'(i), 8'h00, FACTORY_CFG[i], 3'b000);
    u_host_model.query(8'h05, r);
    check(r, 2'b00);
  endtask
  task automatic t_set();
    cmd(8'h22, 8'h03, 8'h00, 8'h64, 8'h09, 2'b10);
    check({RPL_TYPE, RPL_LEN}, {REPLY_SET_PIN, REPLY_LEN});
    idle(3);
    check({PIN_OE[0], PIN_OUT[0]}, 2'b11);
    cmd(8'h22, 8'h02, 8'h00, 8'h00, 8'h02, 2'b10);
    idle(3);
    check({PIN_OE[0], PIN_OUT[0]}, 2'b10);
    qchk(8'h00, 8'h00, 4'h9, 3'b000);
  endtask
  task automatic t_refuse();
    foreach (bad_cmds[k]) cmd(bad_cmds[k][39:32], bad_cmds[k][31:24], bad_cmds[k][23:16],
      bad_cmds[k][15:8], bad_cmds[k][7:0], 2'b00);
    qchk(8'h00, 8'h00, 4'h9, 3'b000);
  endtask
  task automatic t_pwm();
    int hi;
    foreach (pwm_lv[k]) begin
      cmd(8'h22, 8'h02, 8'h00, pwm_lv[k], 8'h00, 2'b10);
      idle(3);
      hi = 0;
      repeat (STEP * PWM_STEPS) begin
        @(negedge CLK);
        if (PIN_OUT[0] === 1'b1) hi++;
      end
      check(32'(hi), 32'(pwm_lv[k]) * STEP);
    end
  endtask
  task automatic t_modes();
    logic [4:0] got;
    for (int m = 0; m < 8; m++) begin
      for (int h = 0; h < 2; h++) begin
        cmd(8'h22, 8'h03, 8'h01, h ? LEVEL_HIGH : LEVEL_LOW, 8'h08 | 8'(m), 2'b10);
        idle(3);
        got = {PIN_OE[1], PIN_OUT[1], PIN_PULL_UP[1], PIN_PULL_DN[1], PIN_SLOW[1] & PIN_OE[1]};
        check(got, mode_exp[m * 2 + h]);
      end
    end
  endtask
  task automatic t_role();
    role_oe = 5'h04;
    role_out = 5'h04;
    idle(3);
    check({PIN_OE[2], PIN_OUT[2]}, 2'b11);
    role_out = 5'h00;
    idle(3);
    check({PIN_OE[2], PIN_OUT[2]}, 2'b10);
    role_oe = 5'h00;
  endtask
  task automatic t_edges();
    pin_in[3] = 1'b1;
    idle(40);
    check(ROLE_IN[3], 1'b1);
    qchk(8'h03, 8'h00, 4'h2, 3'b101);
    qchk(8'h03, 8'h00, 4'h2, 3'b001);
    pin_in[3] = 1'b0;
    idle(40);
    qchk(8'h03, 8'h00, 4'h2, 3'b010);
  endtask
  task automatic t_boot();
    cmd(8'h22, 8'h03, 8'h04, 8'h1e, 8'h0d, 2'b10);
    u_host_model.strobe(1'b1);
    cmd(8'h22, 8'h03, 8'h04, 8'h46, 8'h01, 2'b10);
    u_host_model.strobe(1'b0);
    idle(2);
    qchk(8'h04, 8'h1e, 4'hd, 3'b000);
  endtask
  initial begin
    repeat (20) @(negedge CLK);
    RESET = 1'b0;
    t_reset();
    t_set();
    t_refuse();
    t_pwm();
    t_modes();
    t_role();
    t_edges();
    t_boot();
    wrap_up();
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule
